// file: rtl/sst_pkg.sv
package sst_pkg;
	// clock rate of the core
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
	localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;

	// register map
	localparam logic [7:0] CFG_ADDR = 8'h2C;
	localparam logic [7:0] CFG_RESET = 8'h00;

	// field positions
	localparam int SRC_SEL_HI = 7;
	localparam int SRC_SEL_LO = 6;
	localparam int SW_ON_BIT = 5;
	localparam int DLY_HI = 4;
	localparam int DLY_LO = 3;
	localparam int SOFT_STOP_BIT = 2;
	localparam int RAMP_HI = 1;
	localparam int RAMP_LO = 0;

	// enable source codes
	localparam logic [1:0] SRC_ALWAYS = 2'h0;
	localparam logic [1:0] SRC_PIN = 2'h1;
	localparam logic [1:0] SRC_SW = 2'h2;
	localparam logic [1:0] SRC_BOTH = 2'h3;

	// turn-on delay codes
	localparam logic [1:0] DLY_NONE = 2'h0;
	localparam logic [1:0] DLY_HALF = 2'h1;

	// turn-on delays in ms, soft start ramps in us and ms
	localparam int unsigned DLY_HALF_MS = 500;
	localparam int unsigned DLY_ONE_MS = 1000;
	localparam int unsigned RAMP0_US = 360;
	localparam int unsigned RAMP1_MS = 10;
	localparam int unsigned RAMP2_MS = 20;
	localparam int unsigned RAMP3_MS = 40;

	// derived cycle counts
	localparam logic [31:0] DLY_HALF_CYC = 32'(DLY_HALF_MS * CLK_PER_MS);
	localparam logic [31:0] DLY_ONE_CYC = 32'(DLY_ONE_MS * CLK_PER_MS);
	localparam logic [31:0] RAMP0_CYC = 32'(RAMP0_US * CLK_PER_US);
	localparam logic [31:0] RAMP1_CYC = 32'(RAMP1_MS * CLK_PER_MS);
	localparam logic [31:0] RAMP2_CYC = 32'(RAMP2_MS * CLK_PER_MS);
	localparam logic [31:0] RAMP3_CYC = 32'(RAMP3_MS * CLK_PER_MS);

	// sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_OFF = 4'h1,
		ST_WAIT = 4'h2,
		ST_RAMP = 4'h4,
		ST_ON = 4'h8
	} sst_state_t;
endpackage : sst_pkg

// file: rtl/sst_timer.sv
`timescale 1ns/1ps
// one-shot down counter: expire is high in the len_i-th cycle after start
module sst_timer #(
	parameter int W = 32
) (
	input wire logic clk_i, // core clock
	input wire logic rstn_i, // async reset, active low
	input wire logic start_i, // load and start
	input wire logic [W-1:0] len_i, // length in cycles, at least one
	output logic expire_o // high in the last counted cycle
);
	logic [W-1:0] cnt;

	// a fresh start overrides any count still running
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= '0;
		end else if (start_i) begin
			cnt <= len_i;
		end else if (cnt != '0) begin
			cnt <= cnt - W'(1);
		end
	end

	assign expire_o = (cnt == W'(1));
endmodule : sst_timer

// file: rtl/sst_supply_on.sv
`timescale 1ns/1ps
//Contract
//- bits [7:6] of the config register choose which signal turns the supply on.
//- selector 00 keeps the supply on and ignores both pin and software bit.
//- selector 01 follows only the level of the hardware enable pin.
//- selector 10 follows only the software enable bit at bit 5.
//- selector 11 enables only while both the software bit and the pin are high.
//- bits [4:3] set the wait from enable to soft start: 00 none, 01 half a second, 10 one second.
//- soft start then ramps for 360 us, 10, 20 or 40 ms for codes 00 to 11 of the ramp field.
module sst_supply_on import sst_pkg::*; #(
	parameter logic [31:0] DLY_HALF = DLY_HALF_CYC,
	parameter logic [31:0] DLY_ONE = DLY_ONE_CYC,
	parameter logic [31:0] RAMP0 = RAMP0_CYC,
	parameter logic [31:0] RAMP1 = RAMP1_CYC,
	parameter logic [31:0] RAMP2 = RAMP2_CYC,
	parameter logic [31:0] RAMP3 = RAMP3_CYC
) (
	input wire logic CORE_CLK_I, // core clock, 20 MHz
	input wire logic RSTN_I, // async reset, active low
	input wire logic SUPPLY_ON_PIN_I, // hardware enable pin, asynchronous
	input wire logic REG_WE_I, // register write strobe
	input wire logic [7:0] REG_ADDR_I, // register address
	input wire logic [7:0] REG_WDATA_I, // register write data
	output logic [7:0] REG_RDATA_O, // register read data, one cycle late
	output logic SUPPLY_EN_O, // selected turn-on control
	output logic SOFT_START_O, // soft start ramp running
	output logic SUPPLY_READY_O, // ramp finished, output at nominal
	output logic SOFT_STOP_EN_O // soft stop option from config
);
	logic [7:0] cfg;
	logic pin_m;
	logic pin_s;
	logic en_q;
	logic [7:0] rdata;
	sst_state_t state;
	sst_state_t next_state;
	logic tmr_start;
	logic [31:0] tmr_len;
	logic tmr_expire;

	// register decode
	wire cfg_hit = (REG_ADDR_I == CFG_ADDR);
	wire cfg_wr = REG_WE_I && cfg_hit;
	wire [1:0] src_sel = cfg[SRC_SEL_HI:SRC_SEL_LO];
	wire [1:0] dly_code = cfg[DLY_HI:DLY_LO];
	wire [1:0] ramp_code = cfg[RAMP_HI:RAMP_LO];
	wire sw_on = cfg[SW_ON_BIT];

	// enable source selection
	wire sel_en = (src_sel == SRC_ALWAYS) ? 1'b1 :
		(src_sel == SRC_PIN) ? pin_s :
		(src_sel == SRC_SW) ? sw_on :
		(sw_on && pin_s);

	// code 11 is not defined for the delay; it is treated like one second.
	// the cycle-count parameter hides the package's code of the same name, so the code is reached by scope
	wire [31:0] dly_len = (dly_code == sst_pkg::DLY_HALF) ? DLY_HALF : DLY_ONE;
	wire [31:0] ramp_len = (ramp_code == 2'h0) ? RAMP0 :
		(ramp_code == 2'h1) ? RAMP1 :
		(ramp_code == 2'h2) ? RAMP2 : RAMP3;

	// config register, all fields read back as written
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cfg <= CFG_RESET;
		end else if (cfg_wr) begin
			cfg <= REG_WDATA_I;
		end
	end

	// unmapped addresses read zero
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata <= 8'h00;
		end else begin
			rdata <= cfg_hit ? cfg : 8'h00;
		end
	end

	// pin crosses into the core clock before anyone looks at it
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			pin_m <= 1'b0;
			pin_s <= 1'b0;
		end else begin
			pin_m <= SUPPLY_ON_PIN_I;
			pin_s <= pin_m;
		end
	end

	// registered enable so the output has no decode glitches
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			en_q <= 1'b0;
		end else begin
			en_q <= sel_en;
		end
	end

	// sequencer: enable, optional delay, soft start ramp, on.
	// losing the enable drops straight to off; soft stop is not sequenced here
	always_comb begin
		next_state = state;
		tmr_start = 1'b0;
		tmr_len = ramp_len;
		case (state)
			ST_OFF: begin
				if (sel_en) begin
					tmr_start = 1'b1;
					if (dly_code == DLY_NONE) begin
						next_state = ST_RAMP;
					end else begin
						tmr_len = dly_len;
						next_state = ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (!sel_en) begin
					next_state = ST_OFF;
				end else if (tmr_expire) begin
					tmr_start = 1'b1;
					next_state = ST_RAMP;
				end
			end
			ST_RAMP: begin
				if (!sel_en) begin
					next_state = ST_OFF;
				end else if (tmr_expire) begin
					next_state = ST_ON;
				end
			end
			ST_ON: begin
				if (!sel_en) begin
					next_state = ST_OFF;
				end
			end
			default: begin
				next_state = ST_OFF;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			state <= ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	sst_timer #(
		.W(32)
	) u_timer (
		.clk_i(CORE_CLK_I),
		.rstn_i(RSTN_I),
		.start_i(tmr_start),
		.len_i(tmr_len),
		.expire_o(tmr_expire)
	);

	// outputs straight from flops
	assign REG_RDATA_O = rdata;
	assign SUPPLY_EN_O = en_q;
	assign SOFT_START_O = state[2];
	assign SUPPLY_READY_O = state[3];
	assign SOFT_STOP_EN_O = cfg[SOFT_STOP_BIT];

	// helper: cycles spent in the current state and the length it was started with
	logic [31:0] st_cnt;
	logic [31:0] st_len;
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			st_cnt <= '0;
			st_len <= '0;
		end else begin
			st_cnt <= (next_state != state) ? 32'h0 : st_cnt + 32'h1;
			st_len <= tmr_start ? tmr_len : st_len;
		end
	end

	sequence s_enable_lost;
		!sel_en && (state != ST_OFF);
	endsequence

	// delay ran out while the enable still stands
	sequence s_wait_done;
		(state == ST_WAIT) && sel_en && tmr_expire;
	endsequence

	// ramp ran out while the enable still stands
	sequence s_ramp_done;
		(state == ST_RAMP) && sel_en && tmr_expire;
	endsequence

	src_always_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(src_sel == SRC_ALWAYS) |=> SUPPLY_EN_O) else $error("always-on source did not enable");
	src_pin_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(src_sel == SRC_PIN) |=> (SUPPLY_EN_O == $past(pin_s))) else $error("pin source mismatch");
	src_sw_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(src_sel == SRC_SW) |=> (SUPPLY_EN_O == $past(sw_on))) else $error("software source mismatch");
	src_both_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(src_sel == SRC_BOTH) |=> (SUPPLY_EN_O == $past(sw_on && pin_s))) else $error("and source mismatch");
	no_delay_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(state == ST_OFF) && sel_en && (dly_code == DLY_NONE) |=> SOFT_START_O) else $error("zero delay not skipped");
	delay_len_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(state == ST_WAIT) && sel_en && tmr_expire |-> (st_cnt == st_len - 32'h1)) else $error("turn-on delay wrong");
	ramp_len_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		(state == ST_RAMP) ##1 (state == ST_ON) |-> ($past(st_cnt) == st_len - 32'h1)) else $error("ramp time wrong");
	drop_off_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		s_enable_lost |=> (state == ST_OFF) && !SOFT_START_O && !SUPPLY_READY_O) else $error("enable loss ignored");
	sw_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		cfg_wr ##1 (REG_ADDR_I == CFG_ADDR) |=> (REG_RDATA_O[SW_ON_BIT] == $past(REG_WDATA_I[SW_ON_BIT], 2)))
		else $error("software bit readback wrong");
	wait_to_ramp_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		s_wait_done |=> SOFT_START_O && !SUPPLY_READY_O) else $error("ramp did not follow the delay");
	ramp_to_on_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		s_ramp_done |=> SUPPLY_READY_O && !SOFT_START_O) else $error("ready did not follow the ramp");
	ready_needs_en_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		SUPPLY_READY_O |-> SUPPLY_EN_O) else $error("ready without the selected enable");
	unmapped_zero_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
		!cfg_hit |=> (REG_RDATA_O == 8'h00)) else $error("unmapped address read nonzero");
endmodule : sst_supply_on

// file: dv/sst_host_model.sv
`timescale 1ns/1ps
// host side: enable pin driver and register writer
module sst_host_model (
	input wire logic clk_i, // core clock
	output logic pin_o, // hardware enable pin
	output logic we_o, // write strobe
	output logic [7:0] addr_o, // register address
	output logic [7:0] wdata_o // write data
);
	initial begin
		pin_o = 1'b0;
		we_o = 1'b0;
		addr_o = 8'h2C;
		wdata_o = 8'h00;
	end
	// one-cycle write; data is inverted afterwards so a stale byte never looks valid
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i);
		we_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge clk_i);
		we_o = 1'b0;
		wdata_o = ~d;
	endtask : wr
	// point the read port at an address
	task automatic look(input logic [7:0] a);
		@(negedge clk_i);
		addr_o = a;
	endtask : look
	// pin changes on the falling edge
	task automatic drive_pin(input logic v);
		@(negedge clk_i);
		pin_o = v;
	endtask : drive_pin
endmodule : sst_host_model

// file: dv/sst_supply_on_tb.sv
`timescale 1ns/1ps
module sst_supply_on_tb;
	import sst_pkg::*;
	localparam logic [31:0] DL[4] = '{32'd0, 32'd20, 32'd40, 32'd40};
	// the shortest ramp keeps its real length so the default count is exercised too
	localparam logic [31:0] RL[4] = '{RAMP0_CYC, 32'd8, 32'd12, 32'd16};
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic pin, we, en, ss, rdy, stop;
	logic [7:0] addr, wdata, rdata, cfg;
	logic p;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 13511;
	int i, k, d, r;
	sst_host_model sst_host_model_inst (.clk_i(clk), .pin_o(pin), .we_o(we), .addr_o(addr), .wdata_o(wdata));
	sst_supply_on #(.DLY_HALF(32'd20), .DLY_ONE(32'd40), .RAMP1(32'd8), .RAMP2(32'd12),
		.RAMP3(32'd16)) sst_supply_on_inst (.CORE_CLK_I(clk), .RSTN_I(rstn), .SUPPLY_ON_PIN_I(pin),
		.REG_WE_I(we), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SUPPLY_EN_O(en),
		.SOFT_START_O(ss), .SUPPLY_READY_O(rdy), .SOFT_STOP_EN_O(stop));
	// 20 MHz core clock
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic test_done;
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done
	// a wait that used up its bound ends the run
	task automatic tmo(input int n, input int lim);
		if (n >= lim) begin
			n_mismatch++;
			test_done();
		end
	endtask : tmo
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		sst_host_model_inst.look(a);
		repeat (2) @(negedge clk);
		check(rdata, e);
	endtask : rd_chk
	// expected enable for a source code, pin level and software bit
	function automatic logic exp_en(input logic [1:0] s, input logic pn, input logic b);
		return (s == SRC_ALWAYS) | ((s == SRC_PIN) & pn) | ((s == SRC_SW) & b) | ((s == SRC_BOTH) & pn & b);
	endfunction : exp_en
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) rstn = 1'b1;
		repeat (2) @(negedge clk);
		check(en, 1'b1);
		rd_chk(8'h2C, 8'h00);
		// every source code against random pin levels and both bit values
		for (i = 0; i < 32; i++) begin
			p = 1'($random(seed));
			sst_host_model_inst.drive_pin(p);
			sst_host_model_inst.wr(8'h2C, {i[1:0], i[2], 5'h00});
			repeat (4) @(negedge clk);
			check(en, exp_en(i[1:0], p, i[2]));
		end
		// random read-back, unmapped place reads zero and leaves the register alone
		for (i = 0; i < 4; i++) begin
			cfg = 8'($random(seed));
			sst_host_model_inst.wr(8'h2C, cfg);
			sst_host_model_inst.wr(8'h2D, ~cfg);
			rd_chk(8'h2C, cfg);
			check(stop, cfg[2]);
			rd_chk(8'h2D, 8'h00);
		end
		// every delay and ramp code, software source, started from off
		for (i = 0; i < 16; i++) begin
			sst_host_model_inst.wr(8'h2C, {SRC_SW, 1'b0, i[3:2], 1'b0, i[1:0]});
			repeat (3) @(negedge clk);
			check(en, 1'b0);
			sst_host_model_inst.wr(8'h2C, {SRC_SW, 1'b1, i[3:2], 1'b0, i[1:0]});
			for (k = 0; k < 200 && en !== 1'b1; k++) @(negedge clk);
			tmo(k, 200);
			for (d = 0; d < 200 && ss !== 1'b1; d++) @(negedge clk);
			tmo(d, 200);
			for (r = 0; r < 8000 && ss === 1'b1; r++) @(negedge clk);
			tmo(r, 8000);
			check(d, DL[i[3:2]]);
			check(r, RL[i[1:0]]);
			check(rdy, 1'b1);
		end
		test_done();
	end
endmodule : sst_supply_on_tb
